// ---- src/coc_device.sv ----
// Purpose: Converter control registers behind the serial control port.
// Assumes: Serial pins are asynchronous to clk_sys and pass three flops.
// Notes:   The serial port is reset only by sys_rst, never by power modes.
`timescale 1ns/10ps
module coc_device
	import coc_pkg::*;
(
	input  wire logic        clk_sys,
	input  wire logic        sys_rst,
	coc_link_if.device       link,
	output logic             chip_power_down,
	output logic [1:0]       active_resolution,
	output logic [2:0]       active_rate,
	output logic             datapath_reset,
	output logic             datapath_clk_en,
	output logic             outputs_en,
	output logic             pin_selects_standby,
	output logic             cm_gen_power_down,
	output logic             init_done
);
	// Three-stage synchronisers for sclk, select and data in.
	logic [2:0] s1_reg, s2_reg, s3_reg, filt_reg, filt_next;
	logic [2:0] pin_in;
	assign pin_in = {link.sdio, link.serial_select_n, link.sclk};

	// A change is accepted only once stages two and three agree.
	always_comb begin
		for (int i = 0; i < 3; i++) begin
			filt_next[i] = (s2_reg[i] == s3_reg[i]) ? s3_reg[i] : filt_reg[i];
		end
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			s1_reg   <= 3'h2;
			s2_reg   <= 3'h2;
			s3_reg   <= 3'h2;
			filt_reg <= 3'h2;
		end else begin
			s1_reg   <= pin_in;
			s2_reg   <= s1_reg;
			s3_reg   <= s2_reg;
			filt_reg <= filt_next;
		end
	end

	logic sclk_rise, sclk_fall, sel_act;
	assign sclk_rise = filt_next[0] && !filt_reg[0];
	assign sclk_fall = !filt_next[0] && filt_reg[0];
	assign sel_act   = !filt_reg[1];

	// Serial frame state.
	logic [4:0]  cnt_reg, cnt_next;
	logic [15:0] instr_reg, instr_next;
	logic [7:0]  wsh_reg, wsh_next, osh_reg, osh_next;
	logic        dout_reg, dout_next, doe_reg, doe_next;
	logic        wr_stb;
	logic [7:0]  rd_data;

	// Shift in on rising sclk, shift read data out on falling sclk.
	always_comb begin
		cnt_next   = cnt_reg;
		instr_next = instr_reg;
		wsh_next   = wsh_reg;
		osh_next   = osh_reg;
		dout_next  = dout_reg;
		doe_next   = doe_reg;
		wr_stb     = 1'b0;
		if (!sel_act) begin
			cnt_next = '0;
			doe_next = 1'b0;
		end else if (sclk_rise && cnt_reg != CNT_FRAME) begin
			cnt_next = cnt_reg + 5'h01;
			if (cnt_reg < CNT_INSTR) begin
				instr_next = {instr_reg[14:0], filt_reg[2]};
			end else begin
				wsh_next = {wsh_reg[6:0], filt_reg[2]};
			end
			if (cnt_next == CNT_INSTR) begin
				osh_next = rd_data;
			end
			if (cnt_next == CNT_FRAME && !instr_reg[RW_BIT]) begin
				wr_stb = 1'b1;
			end
		end else if (sclk_fall && cnt_reg >= CNT_INSTR
				&& instr_reg[RW_BIT]) begin
			dout_next = osh_reg[7];
			doe_next  = 1'b1;
			osh_next  = {osh_reg[6:0], 1'b0};
		end
	end

	// Only sys_rst clears the port; power modes never touch it.
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			cnt_reg   <= '0;
			instr_reg <= '0;
			wsh_reg   <= '0;
			osh_reg   <= '0;
			dout_reg  <= 1'b0;
			doe_reg   <= 1'b0;
		end else begin
			cnt_reg   <= cnt_next;
			instr_reg <= instr_next;
			wsh_reg   <= wsh_next;
			osh_reg   <= osh_next;
			dout_reg  <= dout_next;
			doe_reg   <= doe_next;
		end
	end

	// The read word is fetched while the 16th bit is still arriving, so the
	// read address takes that bit from the pin, not from the shifter.
	logic [12:0] addr, rd_addr;
	logic [7:0]  wdata;
	assign addr    = instr_reg[ADDR_W-1:0];
	assign rd_addr = {instr_reg[ADDR_W-2:0], filt_reg[2]};
	assign wdata   = {wsh_reg[6:0], filt_reg[2]};

	// Register bank and applied override.
	logic [7:0] pmode_reg, pmode_next, ovr_reg, ovr_next;
	logic [7:0] uio2_reg, uio2_next, uio3_reg, uio3_next;
	logic [1:0] res_reg, res_next, res_req;
	logic [2:0] rate_reg, rate_next, rate_req;
	logic       pd_reg, pd_next, init_load;

	// Writes land at once except the override, which waits for transfer.
	always_comb begin
		pmode_next = pmode_reg;
		ovr_next   = ovr_reg;
		uio2_next  = uio2_reg;
		uio3_next  = uio3_reg;
		res_next   = res_reg;
		rate_next  = rate_reg;
		pd_next    = pd_reg;
		res_req    = ovr_reg[RES_LSB +: 2];
		rate_req   = ovr_reg[RATE_LSB +: 3];
		if (res_req == GRADE_DEF_RES) begin
			res_req = FACTORY_RES;
		end
		if (rate_req == GRADE_DEF_RATE) begin
			rate_req = FACTORY_RATE;
		end
		if (init_load) begin
			res_next  = FACTORY_RES;
			rate_next = FACTORY_RATE;
			pd_next   = 1'b0;
		end
		if (wr_stb) begin
			case (addr)
				ADDR_PMODE: pmode_next = wdata & MASK_PMODE;
				ADDR_OVR:   ovr_next   = wdata & MASK_OVR;
				ADDR_UIO2:  uio2_next  = wdata & MASK_UIO2;
				ADDR_UIO3:  uio3_next  = wdata & MASK_UIO3;
				ADDR_XFER: begin
					if (wdata[XFER_BIT]) begin
						res_next  = res_req;
						rate_next = rate_req;
						pd_next   = (res_req > FACTORY_RES)
							|| (rate_req > FACTORY_RATE);
					end
				end
				default: ;
			endcase
		end
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			pmode_reg <= RST_REG;
			ovr_reg   <= RST_REG;
			uio2_reg  <= RST_REG;
			uio3_reg  <= RST_REG;
			res_reg   <= FACTORY_RES;
			rate_reg  <= FACTORY_RATE;
			pd_reg    <= 1'b0;
		end else begin
			pmode_reg <= pmode_next;
			ovr_reg   <= ovr_next;
			uio2_reg  <= uio2_next;
			uio3_reg  <= uio3_next;
			res_reg   <= res_next;
			rate_reg  <= rate_next;
			pd_reg    <= pd_next;
		end
	end

	// Read mux; transfer is self-clearing and unmapped reads return zero.
	always_comb begin
		case (rd_addr)
			ADDR_PMODE: rd_data = pmode_reg;
			ADDR_OVR:   rd_data = ovr_reg;
			ADDR_UIO2:  rd_data = uio2_reg;
			ADDR_UIO3:  rd_data = uio3_reg;
			default:    rd_data = 8'h00;
		endcase
	end

	// Init sequence: bias settle, load defaults, run; mode 11 holds it.
	coc_init_t  ist_reg, ist_next;
	logic [7:0] bcnt_reg, bcnt_next;
	logic [1:0] pm;
	assign pm = pmode_reg[1:0];

	always_comb begin
		ist_next  = ist_reg;
		bcnt_next = bcnt_reg;
		init_load = 1'b0;
		case (ist_reg)
			INIT_BIAS: begin
				bcnt_next = bcnt_reg + 8'h01;
				if (bcnt_reg == BIAS_LAST) begin
					ist_next = INIT_REGS;
				end
			end
			INIT_REGS: begin
				init_load = 1'b1;
				ist_next  = INIT_READY;
			end
			INIT_READY: begin
				if (pm == PM_DRESET) begin
					ist_next = INIT_HOLD;
				end
			end
			INIT_HOLD: begin
				bcnt_next = 8'h00;
				if (pm != PM_DRESET) begin
					ist_next = INIT_BIAS;
				end
			end
			default: ist_next = INIT_BIAS;
		endcase
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			ist_reg  <= INIT_BIAS;
			bcnt_reg <= 8'h00;
		end else begin
			ist_reg  <= ist_next;
			bcnt_reg <= bcnt_next;
		end
	end

	// Datapath controls follow the power mode while the init is done and chip_power_down is low.
	logic ready;
	assign ready = (ist_reg == INIT_READY) && !pd_reg;
	assign datapath_reset = !ready || pm == PM_DRESET
		|| pm == PM_PDOWN;
	assign datapath_clk_en     = ready && pm == PM_NORMAL;
	assign outputs_en          = ready && pm == PM_NORMAL;
	assign init_done           = (ist_reg == INIT_READY);
	assign chip_power_down     = pd_reg;
	assign active_resolution   = res_reg;
	assign active_rate         = rate_reg;
	assign pin_selects_standby = pmode_reg[PIN_SBY_BIT];
	assign cm_gen_power_down   = uio3_reg[CM_PD_BIT];
	assign link.sdio_pulldown_en = !uio2_reg[PULLDN_OFF_BIT];
	assign link.sdio_dev_o     = dout_reg;
	assign link.sdio_dev_oe    = doe_reg;
endmodule

// ---- src/coc_host.sv ----
// Purpose: Serial control port host issuing single register accesses.
// Assumes: Same clock as the requesting logic; sclk made by a divider.
// Notes:   Between frames all pins stay still to keep the converter quiet.
`timescale 1ns/10ps
module coc_host
	import coc_pkg::*;
(
	input  wire logic        clk_sys,
	input  wire logic        sys_rst,
	coc_link_if.host         link,
	input  wire logic        req_valid,
	input  wire logic        req_write,
	input  wire logic [12:0] req_addr,
	input  wire logic [7:0]  req_wdata,
	input  wire logic        dreset_req,
	output logic             req_ready,
	output logic             done,
	output logic [7:0]       rd_data
);
	coc_host_t   st_reg, st_next;
	logic [3:0]  div_reg, div_next;
	logic [4:0]  bit_reg, bit_next;
	logic [23:0] sh_reg, sh_next;
	logic [7:0]  rd_reg, rd_next;
	logic        rd_mode_reg, rd_mode_next, dr_reg, dr_next, done_next;
	logic        done_reg;

	// Frame sequencer; a digital reset is two back-to-back mode writes.
	always_comb begin
		st_next      = st_reg;
		div_next     = div_reg;
		bit_next     = bit_reg;
		sh_next      = sh_reg;
		rd_next      = rd_reg;
		rd_mode_next = rd_mode_reg;
		dr_next      = dr_reg;
		done_next    = 1'b0;
		case (st_reg)
			HST_IDLE: begin
				div_next = 4'h0;
				bit_next = 5'h00;
				if (dreset_req) begin
					sh_next      = {1'b0, 2'b00, ADDR_PMODE, CMD_DRESET};
					rd_mode_next = 1'b0;
					dr_next      = 1'b1;
					st_next      = HST_LOW;
				end else if (req_valid) begin
					sh_next      = {!req_write, 2'b00, req_addr, req_wdata};
					rd_mode_next = !req_write;
					st_next      = HST_LOW;
				end
			end
			HST_LOW: begin
				div_next = div_reg + 4'h1;
				if (div_reg == HALF_LAST) begin
					div_next = 4'h0;
					st_next  = HST_HIGH;
					if (rd_mode_reg && bit_reg >= CNT_INSTR) begin
						rd_next = {rd_reg[6:0], link.sdio};
					end
				end
			end
			HST_HIGH: begin
				div_next = div_reg + 4'h1;
				if (div_reg == HALF_LAST) begin
					div_next = 4'h0;
					bit_next = bit_reg + 5'h01;
					sh_next  = {sh_reg[22:0], 1'b0};
					st_next  = (bit_next == CNT_FRAME) ? HST_GAP : HST_LOW;
				end
			end
			HST_GAP: begin
				div_next = div_reg + 4'h1;
				if (div_reg == HALF_LAST) begin
					div_next = 4'h0;
					bit_next = 5'h00;
					if (dr_reg) begin
						sh_next = {1'b0, 2'b00, ADDR_PMODE, CMD_NORMAL};
						dr_next = 1'b0;
						st_next = HST_LOW;
					end else begin
						done_next = 1'b1;
						st_next   = HST_IDLE;
					end
				end
			end
			default: st_next = HST_IDLE;
		endcase
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			st_reg      <= HST_IDLE;
			div_reg     <= 4'h0;
			bit_reg     <= 5'h00;
			sh_reg      <= '0;
			rd_reg      <= 8'h00;
			rd_mode_reg <= 1'b0;
			dr_reg      <= 1'b0;
			done_reg    <= 1'b0;
		end else begin
			st_reg      <= st_next;
			div_reg     <= div_next;
			bit_reg     <= bit_next;
			sh_reg      <= sh_next;
			rd_reg      <= rd_next;
			rd_mode_reg <= rd_mode_next;
			dr_reg      <= dr_next;
			done_reg    <= done_next;
		end
	end

	// Select low only inside a frame; data released during read bits.
	logic in_frame;
	assign in_frame             = (st_reg == HST_LOW) || (st_reg == HST_HIGH);
	assign link.sclk            = (st_reg == HST_HIGH);
	assign link.serial_select_n = !in_frame;
	assign link.sdio_host_o     = in_frame && sh_reg[23];
	assign link.sdio_host_oe    = in_frame
		&& !(rd_mode_reg && bit_reg >= CNT_INSTR);
	assign req_ready            = (st_reg == HST_IDLE) && !dreset_req;
	assign done                 = done_reg;
	assign rd_data              = rd_reg;
endmodule

// ---- src/coc_link_if.sv ----
// Purpose: Serial control port wires between host and converter control.
// Assumes: One clock; the data line is resolved here from both enables.
// Notes:   Undriven data reads low while the weak pull-down is on.
`timescale 1ns/10ps
interface coc_link_if;
	logic sclk;
	logic serial_select_n;
	logic sdio_host_o;
	logic sdio_host_oe;
	logic sdio_dev_o;
	logic sdio_dev_oe;
	logic sdio_pulldown_en;
	logic sdio;
	// Wire level: a driver wins, otherwise the pull-down or an idle high.
	assign sdio = sdio_host_oe ? sdio_host_o :
		(sdio_dev_oe ? sdio_dev_o : !sdio_pulldown_en);
	modport host (output sclk, output serial_select_n, output sdio_host_o,
		output sdio_host_oe, input sdio);
	modport device (input sclk, input serial_select_n, output sdio_dev_o,
		output sdio_dev_oe, output sdio_pulldown_en, input sdio);
endinterface

// ---- src/coc_pkg.sv ----
// Purpose: Shared constants for the converter override and init control.
// Assumes: 10 MHz system clock, 13-bit register addresses, 8-bit data.
// Notes:   Serial frame is 16 instruction bits then 8 data bits, MSB first.
package coc_pkg;
	localparam int          CLK_NS         = 100;
	localparam int          ADDR_W         = 13;
	localparam int          DATA_W         = 8;
	localparam int          INSTR_BITS     = 16;
	localparam int          FRAME_BITS     = 24;
	localparam int          CNT_W          = 5;
	localparam logic [4:0]  CNT_INSTR      = 5'h10;
	localparam logic [4:0]  CNT_FRAME      = 5'h18;
	localparam int          RW_BIT         = 15;
	// Register offsets.
	localparam logic [12:0] ADDR_PMODE     = 13'h0008;
	localparam logic [12:0] ADDR_XFER      = 13'h00ff;
	localparam logic [12:0] ADDR_OVR       = 13'h0100;
	localparam logic [12:0] ADDR_UIO2      = 13'h0101;
	localparam logic [12:0] ADDR_UIO3      = 13'h0102;
	// Writable bits of each register; open bits read zero.
	localparam logic [7:0]  MASK_PMODE     = 8'h23;
	localparam logic [7:0]  MASK_OVR       = 8'h37;
	localparam logic [7:0]  MASK_UIO2      = 8'h01;
	localparam logic [7:0]  MASK_UIO3      = 8'h08;
	localparam logic [7:0]  RST_REG        = 8'h00;
	// Field positions.
	localparam int          XFER_BIT       = 0;
	localparam int          PULLDN_OFF_BIT = 0;
	localparam int          CM_PD_BIT      = 3;
	localparam int          PIN_SBY_BIT    = 5;
	localparam int          RES_LSB        = 4;
	localparam int          RATE_LSB       = 0;
	// Power modes and commands.
	localparam logic [1:0]  PM_NORMAL      = 2'h0;
	localparam logic [1:0]  PM_PDOWN       = 2'h1;
	localparam logic [1:0]  PM_STANDBY     = 2'h2;
	localparam logic [1:0]  PM_DRESET      = 2'h3;
	localparam logic [7:0]  CMD_DRESET     = 8'h03;
	localparam logic [7:0]  CMD_NORMAL     = 8'h00;
	// Grade codes: 0 keeps the factory grade, larger means faster or finer.
	localparam logic [1:0]  GRADE_DEF_RES  = 2'h0;
	localparam logic [2:0]  GRADE_DEF_RATE = 3'h0;
	localparam logic [1:0]  FACTORY_RES    = 2'h2;
	localparam logic [2:0]  FACTORY_RATE   = 3'h4;
	// Bias settling time of the init sequence.
	localparam int          BIAS_NS        = 2000;
	localparam int          BIAS_CYC       = (BIAS_NS + CLK_NS - 1) / CLK_NS;
	localparam logic [7:0]  BIAS_LAST      = 8'(BIAS_CYC - 1);
	// Host serial clock half period in system clocks.
	localparam logic [3:0]  HALF_LAST      = 4'h7;
	typedef enum logic [1:0] {
		INIT_BIAS  = 2'b00,
		INIT_REGS  = 2'b01,
		INIT_READY = 2'b11,
		INIT_HOLD  = 2'b10
	} coc_init_t;
	typedef enum logic [1:0] {
		HST_IDLE  = 2'b00,
		HST_LOW   = 2'b01,
		HST_HIGH  = 2'b11,
		HST_GAP   = 2'b10
	} coc_host_t;
endpackage

// ---- test/coc_monitor.sv ----
// Purpose: Checks the converter control and its serial link from outside.
// Assumes: One clock domain, synchronous active-high reset.
// Notes:   Only settled relations are checked; serial lag is not counted.
`timescale 1ns/10ps
module coc_monitor (
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic sclk,
	input wire logic serial_select_n,
	input wire logic sdio_pulldown_en,
	input wire logic chip_power_down,
	input wire logic datapath_reset,
	input wire logic datapath_clk_en,
	input wire logic outputs_en,
	input wire logic cm_gen_power_down,
	input wire logic init_done
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (sys_rst);
	// The init sequence must stay not ready for 8 cycles, then report ready 8 to 20 cycles later.
	sequence init_wait;
		!init_done [*8];
	endsequence
	sequence init_up;
		##[8:20] init_done;
	endsequence
	init_seq_a: assert property ($fell(sys_rst) |-> init_wait ##0 init_up)
		else $error("init did not finish in time");
	init_gate_a: assert property (!init_done |-> datapath_reset)
		else $error("datapath left reset before init finished");
	pd_frame_a: assert property ($rose(chip_power_down) |->
		!$past(serial_select_n)) else $error("power down outside a frame");
	pd_block_a: assert property (chip_power_down |->
		datapath_reset && !outputs_en) else $error("power down not applied");
	path_gate_a: assert property (datapath_clk_en |-> init_done &&
		!datapath_reset && outputs_en) else $error("clock on in wrong mode");
	pulldn_frame_a: assert property ($changed(sdio_pulldown_en) |->
		!$past(serial_select_n)) else $error("pull-down moved off a write");
	cm_frame_a: assert property ($changed(cm_gen_power_down) |->
		!$past(serial_select_n)) else $error("common-mode moved off a write");
	sclk_idle_a: assert property ($rose(sclk) |-> !serial_select_n)
		else $error("serial clock toggled outside a frame");
endmodule

// ---- test/tb.sv ----
// Purpose: Self-checking bench for host and converter control together.
// Assumes: Host done is a one-cycle pulse; frames take about 400 cycles.
// Notes:   Outputs are read 1 ns after an edge so its updates have landed.
`timescale 1ns/10ps
module tb;
	import coc_pkg::*;
	logic clk_sys, sys_rst, req_valid, req_write, dreset_req;
	logic [12:0] req_addr;
	logic [7:0] req_wdata, rd_data;
	logic req_ready, done, chip_power_down, datapath_reset;
	logic datapath_clk_en, outputs_en, pin_selects_standby;
	logic cm_gen_power_down, init_done;
	logic [1:0] active_resolution;
	logic [2:0] active_rate;
	int bad_count, cmp_count, cyc;
	coc_link_if link ();
	coc_device coc_device_i (.clk_sys(clk_sys), .sys_rst(sys_rst),
		.link(link), .chip_power_down(chip_power_down),
		.active_resolution(active_resolution), .active_rate(active_rate),
		.datapath_reset(datapath_reset), .datapath_clk_en(datapath_clk_en),
		.outputs_en(outputs_en), .pin_selects_standby(pin_selects_standby),
		.cm_gen_power_down(cm_gen_power_down), .init_done(init_done));
	coc_host coc_host_i (.clk_sys(clk_sys), .sys_rst(sys_rst), .link(link),
		.req_valid(req_valid), .req_write(req_write), .req_addr(req_addr),
		.req_wdata(req_wdata), .dreset_req(dreset_req),
		.req_ready(req_ready), .done(done), .rd_data(rd_data));
	coc_monitor coc_monitor_i (.clk_sys(clk_sys), .sys_rst(sys_rst),
		.sclk(link.sclk), .serial_select_n(link.serial_select_n),
		.sdio_pulldown_en(link.sdio_pulldown_en),
		.chip_power_down(chip_power_down), .datapath_reset(datapath_reset),
		.datapath_clk_en(datapath_clk_en), .outputs_en(outputs_en),
		.cm_gen_power_down(cm_gen_power_down), .init_done(init_done));
	initial begin
		clk_sys = 1'b0;
		forever #(CLK_NS / 2) clk_sys = !clk_sys;
	end
	task automatic results();
		if (bad_count == 0 && cmp_count > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	// A hang is cut short well above the roughly 7500 cycles the run needs.
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 20000) begin
			bad_count++;
			results();
		end
	end
	task automatic chk(string s, logic [7:0] e, logic [7:0] v);
		cmp_count++;
		if (v !== e) begin
			bad_count++;
			$display("MISMATCH %s expected %h seen %h", s, e, v);
		end
	endtask
	// Waits for the host's done pulse, counting a hang as a mismatch.
	task automatic wait_done();
		int n;
		n = 0;
		while (done !== 1'b1 && n < 1000) begin
			@(posedge clk_sys);
			#1;
			n++;
		end
		chk("done", 8'h01, {7'h00, done});
	endtask
	// One access: the request is held until an edge finds the host idle.
	task automatic acc(logic w, logic [12:0] a, logic [7:0] d);
		logic ok;
		@(posedge clk_sys);
		req_valid <= 1'b1;
		req_write <= w;
		req_addr <= a;
		req_wdata <= d;
		// Ready is read between edges, so it is what the next edge sees.
		do begin
			#1;
			ok = (req_ready === 1'b1);
			@(posedge clk_sys);
		end while (!ok);
		req_valid <= 1'b0;
		#1;
		wait_done();
	endtask
	task automatic regs_mask();
		logic [12:0] a [4] = '{ADDR_UIO2, ADDR_UIO3, ADDR_OVR, 13'h0055};
		logic [7:0] e [4] = '{8'h01, 8'h08, 8'h12, 8'h00};
		for (int i = 0; i < 4; i++) begin
			acc(1'b1, a[i], 8'hff ^ (i == 2 ? 8'hed : 8'h00));
			acc(1'b0, a[i], 8'h00);
			chk("readback", e[i], rd_data);
		end
		chk("pulldown", 8'h00, {7'h00, link.sdio_pulldown_en});
		chk("cm_pd", 8'h01, {7'h00, cm_gen_power_down});
		chk("res_held", {6'h00, FACTORY_RES}, {6'h00, active_resolution});
		acc(1'b1, ADDR_PMODE, 8'h20);
		chk("standby_pin", 8'h01, {7'h00, pin_selects_standby});
	endtask
	task automatic transfer_ok();
		acc(1'b1, ADDR_XFER, 8'h01);
		chk("res", 8'h01, {6'h00, active_resolution});
		chk("rate", 8'h02, {5'h00, active_rate});
		chk("pd_legal", 8'h00, {7'h00, chip_power_down});
		acc(1'b0, ADDR_XFER, 8'h00);
		chk("xfer_read", 8'h00, rd_data);
	endtask
	task automatic upgrade();
		acc(1'b1, ADDR_OVR, 8'h35);
		chk("pd_early", 8'h00, {7'h00, chip_power_down});
		acc(1'b1, ADDR_XFER, 8'h01);
		chk("pd_up", 8'h01, {7'h00, chip_power_down});
		chk("out_off", 8'h00, {7'h00, outputs_en});
	endtask
	task automatic dreset();
		int n;
		logic seen_low;
		seen_low = 1'b0;
		n = 0;
		@(posedge clk_sys);
		dreset_req <= 1'b1;
		@(posedge clk_sys);
		dreset_req <= 1'b0;
		while (done !== 1'b1 && n < 1000) begin
			@(posedge clk_sys);
			#1;
			seen_low |= (init_done === 1'b0);
			n++;
		end
		chk("init_rerun", 8'h01, {7'h00, seen_low});
		repeat (25) @(posedge clk_sys);
		#1;
		chk("init_back", 8'h01, {7'h00, init_done});
		chk("pd_clear", 8'h00, {7'h00, chip_power_down});
		chk("res_def", {6'h00, FACTORY_RES}, {6'h00, active_resolution});
		chk("port_kept", 8'h01, {7'h00, cm_gen_power_down});
		acc(1'b0, ADDR_PMODE, 8'h00);
		chk("pmode_read", 8'h00, rd_data);
	endtask
	task automatic modes();
		logic [7:0] m [3] = '{8'h01, 8'h02, 8'h00};
		logic [2:0] e [3] = '{3'h4, 3'h0, 3'h3};
		for (int i = 0; i < 3; i++) begin
			acc(1'b1, ADDR_PMODE, m[i]);
			chk("mode_out", {5'h00, e[i]}, {5'h00, datapath_reset,
				datapath_clk_en, outputs_en});
		end
	endtask
	// Power-on: the init sequence must report ready with factory defaults.
	task automatic power_on();
		repeat (25) @(posedge clk_sys);
		#1;
		chk("init", 8'h01, {7'h00, init_done});
		chk("rate_def", {5'h00, FACTORY_RATE}, {5'h00, active_rate});
		chk("pd_rst", 8'h01, {7'h00, link.sdio_pulldown_en});
	endtask
	initial begin
		sys_rst = 1'b1;
		req_valid = 1'b0;
		req_write = 1'b0;
		req_addr = 13'h0000;
		req_wdata = 8'h00;
		dreset_req = 1'b0;
		repeat (6) @(posedge clk_sys);
		sys_rst <= 1'b0;
		power_on();
		regs_mask();
		transfer_ok();
		upgrade();
		dreset();
		modes();
		results();
	end
endmodule
